// *** hw/usn_notify.sv ***
// Serial-state notification framer and pad pull settings
//
// Operation
// - Format bit 0 picks standard or custom packet
// - Byte 0 is class, device-to-host, interface
// - Byte 1 is serial state notification code
// - wValue zero, wIndex interface zero
// - wLength two; custom payload four bytes
// - Standard payload bit layout, upper bits zero
// - Custom bits 19:16 sticky line errors
// - Custom bits 13:8 pin levels at generation
// - Custom bits 5:0 sticky pin changes
// - Pull-up enables, reset all enabled
// - Pull-down enables, reset all disabled
// - Pull-up set forces pull-down off
// - Unmasked pin change triggers a packet
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module usn_notify
    import usn_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    input  wire logic                  clk_en,
    input  wire usn_reg_req_s          reg_req,
    output var  logic [REG_DATA_W-1:0] reg_rdata,
    input  wire usn_uart_evt_s         uart_evt,
    input  wire logic [NUM_PINS-1:0]   modem_pins,
    input  wire logic                  pkt_ready,
    output var  usn_pkt_s              pkt,
    output var  logic [PAD_W-1:0]      pullup_en,
    output var  logic [PAD_W-1:0]      pulldown_en,
    output var  logic                  irq
);

    generate
        if (SYNC_STAGES < 2) begin : g_bad_sync
            $error("SYNC_STAGES must be at least 2");
        end
    endgenerate

    // Registers
    logic                  fmt_custom;
    logic [PAD_W-1:0]      pu_reg;
    logic [PAD_W-1:0]      pd_reg;
    logic [NUM_PINS-1:0]   gpio_mask;
    logic [IRQ_W-1:0]      irq_stat;
    logic [IRQ_W-1:0]      irq_mask;

    // Sticky activity
    logic [NUM_ERRS-1:0]   err_flags;
    logic [NUM_PINS-1:0]   chg_flags;
    logic                  pending;

    // Pin synchroniser
    logic [NUM_PINS-1:0]   pin_sync [SYNC_STAGES];
    logic [NUM_PINS-1:0]   pin_lvl;
    logic [NUM_PINS-1:0]   pin_prev;
    logic [NUM_PINS-1:0]   pin_toggle;
    logic [SYNC_STAGES:0]  fill;
    logic                  primed;

    // Framer
    usn_state_e            state;
    logic [3:0]            byte_idx;
    logic [3:0]            last_idx;
    logic [31:0]           payload;
    logic                  start;
    logic                  advance;
    logic [7:0]            next_byte;
    logic [31:0]           next_payload;
    logic                  cus_pkt;

    logic                  wr_hit;
    logic                  rd_stat;
    logic [NUM_ERRS-1:0]   err_in;
    logic [IRQ_W-1:0]      irq_set;

    assign err_in     = uart_evt;
    assign pin_lvl    = pin_sync[SYNC_STAGES-1];
    assign primed     = fill[SYNC_STAGES];
    assign pin_toggle = primed ? (pin_lvl ^ pin_prev) : '0;
    assign wr_hit     = clk_en && reg_req.wr;
    assign rd_stat    = clk_en && reg_req.rd && reg_req.addr == OFS_IRQ_STAT;

    // Pins pass the full chain before anything reads them
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                pin_sync[i] <= '0;
            end
            pin_prev <= '0;
        end else if (clk_en) begin
            pin_sync[0] <= modem_pins;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                pin_sync[i] <= pin_sync[i-1];
            end
            pin_prev <= pin_lvl;
        end
    end

    // Toggles ignored until pin_prev holds a real level;
    // pins idle high under the default pull-ups, so a
    // reset-time compare would fake a change
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fill <= '0;
        end else if (clk_en) begin
            fill <= {fill[SYNC_STAGES-1:0], 1'b1};
        end
    end

    // Register writes, reserved bits dropped
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fmt_custom <= FORMAT_RST;
            pu_reg     <= PULLUP_RST;
            pd_reg     <= PULLDOWN_RST;
            gpio_mask  <= GPIO_MASK_RST;
            irq_mask   <= IRQ_MASK_RST;
        end else if (wr_hit) begin
            if (reg_req.addr == OFS_FORMAT) begin
                fmt_custom <= reg_req.wdata[FMT_CUSTOM_BIT];
            end else if (reg_req.addr == OFS_PULLUP) begin
                pu_reg <= reg_req.wdata[PAD_W-1:0];
            end else if (reg_req.addr == OFS_PULLDOWN) begin
                pd_reg <= reg_req.wdata[PAD_W-1:0];
            end else if (reg_req.addr == OFS_GPIO_MASK) begin
                gpio_mask <= reg_req.wdata[NUM_PINS-1:0];
            end else if (reg_req.addr == OFS_IRQ_MASK) begin
                irq_mask <= reg_req.wdata[IRQ_W-1:0];
            end
        end
    end

    // Pad controls; pull-up always wins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pullup_en   <= PULLUP_RST;
            pulldown_en <= PULLDOWN_RST;
        end else if (clk_en) begin
            pullup_en   <= pu_reg;
            pulldown_en <= pd_reg & ~pu_reg;
        end
    end

    // Read data stands one cycle only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= '0;
            if (reg_req.rd) begin
                if (reg_req.addr == OFS_FORMAT) begin
                    reg_rdata[FMT_CUSTOM_BIT] <= fmt_custom;
                end else if (reg_req.addr == OFS_PULLUP) begin
                    reg_rdata[PAD_W-1:0] <= pu_reg;
                end else if (reg_req.addr == OFS_PULLDOWN) begin
                    reg_rdata[PAD_W-1:0] <= pd_reg;
                end else if (reg_req.addr == OFS_GPIO_MASK) begin
                    reg_rdata[NUM_PINS-1:0] <= gpio_mask;
                end else if (reg_req.addr == OFS_IRQ_STAT) begin
                    reg_rdata[IRQ_W-1:0] <= irq_stat;
                end else if (reg_req.addr == OFS_IRQ_MASK) begin
                    reg_rdata[IRQ_W-1:0] <= irq_mask;
                end else if (reg_req.addr == OFS_FLAGS) begin
                    reg_rdata <= {2'h0, err_flags, 4'h0, chg_flags};
                end
            end
        end
    end

    // Sticky line errors and pin changes.
    // Snapshot and clear at packet start; a new event
    // in that cycle survives for the next packet.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            err_flags <= '0;
            chg_flags <= '0;
        end else if (clk_en) begin
            err_flags <= (start ? '0 : err_flags) | err_in;
            chg_flags <= (start ? '0 : chg_flags) | pin_toggle;
        end
    end

    // Packet request: any line error or unmasked pin change
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pending <= 1'b0;
        end else if (clk_en) begin
            pending <= (pending && !start) || (|err_in)
                || (|(pin_toggle & ~gpio_mask));
        end
    end

    assign start   = clk_en && state == ST_IDLE && pending;
    assign advance = clk_en && state == ST_SEND && pkt.valid && pkt_ready;
    // Length follows the latched format, not the live register
    assign cus_pkt = (last_idx == LAST_CUS);

    // Payload snapshot, taken from the flags plus any event in this same cycle
    always_comb begin
        next_payload = '0;
        if (fmt_custom) begin
            next_payload[CUS_ERR_LSB +: NUM_ERRS]   = err_flags | err_in;
            next_payload[CUS_STATE_LSB +: NUM_PINS] = pin_lvl;
            next_payload[CUS_CHG_LSB +: NUM_PINS]   = chg_flags | pin_toggle;
        end else begin
            next_payload[STD_OVR] = err_flags[E_OVR] | err_in[E_OVR];
            next_payload[STD_PAR] = err_flags[E_PAR] | err_in[E_PAR];
            next_payload[STD_FRM] = err_flags[E_FRM] | err_in[E_FRM];
            next_payload[STD_BRK] = err_flags[E_BRK] | err_in[E_BRK];
            next_payload[STD_RI]  = pin_lvl[M_RI];
            next_payload[STD_DSR] = pin_lvl[M_DSR];
            next_payload[STD_DCD] = pin_lvl[M_CD];
        end
    end

    // Byte mux; payload goes out low byte first
    always_comb begin
        next_byte = 8'h00;
        case (byte_idx)
            4'h0: next_byte = REQ_TYPE;
            4'h1: next_byte = NOTIF_CODE;
            4'h2: next_byte = WVALUE[7:0];
            4'h3: next_byte = WVALUE[15:8];
            4'h4: next_byte = WINDEX[7:0];
            4'h5: next_byte = WINDEX[15:8];
            4'h6: next_byte = cus_pkt ? WLEN_CUS[7:0] : WLEN_STD[7:0];
            4'h7: next_byte = cus_pkt ? WLEN_CUS[15:8] : WLEN_STD[15:8];
            4'h8: next_byte = payload[7:0];
            4'h9: next_byte = payload[15:8];
            4'hA: next_byte = payload[23:16];
            4'hB: next_byte = payload[31:24];
            default: next_byte = 8'h00;
        endcase
    end

    // Framer: format is latched per packet so a
    // mid-packet register write cannot tear it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state    <= ST_IDLE;
            byte_idx <= 4'h0;
            last_idx <= LAST_STD;
            payload  <= '0;
            pkt      <= '0;
        end else if (clk_en) begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state      <= ST_SEND;
                        payload    <= next_payload;
                        last_idx   <= fmt_custom ? LAST_CUS : LAST_STD;
                        byte_idx   <= 4'h1;
                        pkt.valid  <= 1'b1;
                        pkt.last   <= 1'b0;
                        pkt.data   <= REQ_TYPE;
                    end
                end
                ST_SEND: begin
                    if (advance) begin
                        if (pkt.last) begin
                            state     <= ST_IDLE;
                            byte_idx  <= 4'h0;
                            pkt.valid <= 1'b0;
                            pkt.last  <= 1'b0;
                            pkt.data  <= 8'h00;
                        end else begin
                            pkt.data <= next_byte;
                            pkt.last <= byte_idx == last_idx;
                            byte_idx <= byte_idx + 4'h1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign irq_set[IRQ_SENT] = advance && pkt.last;
    assign irq_set[IRQ_ERR]  = |err_in;
    assign irq_set[IRQ_CHG]  = |pin_toggle;

    // Status clears on read; a same-cycle event wins
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq_stat <= '0;
        end else if (clk_en) begin
            irq_stat <= (rd_stat ? '0 : irq_stat) | irq_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(irq_stat & irq_mask);
        end
    end

endmodule

`default_nettype wire

// *** include/usn_pkg.sv ***
// Constants, types and carriers of the UART status notifier
package usn_pkg;

    // Register port
    localparam int          REG_ADDR_W    = 8;
    localparam int          REG_DATA_W    = 16;
    localparam logic [7:0]  OFS_GPIO_MASK = 8'h51;
    localparam logic [7:0]  OFS_FORMAT    = 8'h52;
    localparam logic [7:0]  OFS_PULLUP    = 8'h54;
    localparam logic [7:0]  OFS_PULLDOWN  = 8'h55;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h70;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h71;
    localparam logic [7:0]  OFS_FLAGS     = 8'h72;

    // Reset values
    localparam logic        FORMAT_RST    = 1'b0;
    localparam logic [7:0]  PULLUP_RST    = 8'hFF;
    localparam logic [7:0]  PULLDOWN_RST  = 8'h00;
    localparam logic [5:0]  GPIO_MASK_RST = 6'h00;
    localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

    // Field positions
    localparam int FMT_CUSTOM_BIT = 0;
    localparam int PAD_W          = 8;
    localparam int NUM_PINS       = 6;
    localparam int NUM_ERRS       = 4;

    // Modem pin order, RTS highest
    localparam int M_RTS = 5;
    localparam int M_CTS = 4;
    localparam int M_DTR = 3;
    localparam int M_DSR = 2;
    localparam int M_CD  = 1;
    localparam int M_RI  = 0;

    // Sticky line error order
    localparam int E_OVR = 3;
    localparam int E_PAR = 2;
    localparam int E_FRM = 1;
    localparam int E_BRK = 0;

    // Standard payload bits
    localparam int STD_OVR = 6;
    localparam int STD_PAR = 5;
    localparam int STD_FRM = 4;
    localparam int STD_RI  = 3;
    localparam int STD_BRK = 2;
    localparam int STD_DSR = 1;
    localparam int STD_DCD = 0;

    // Custom payload fields
    localparam int CUS_ERR_LSB   = 16;
    localparam int CUS_STATE_LSB = 8;
    localparam int CUS_CHG_LSB   = 0;

    // Notification header
    localparam logic [7:0]  REQ_TYPE    = 8'hA1;
    localparam logic [7:0]  NOTIF_CODE  = 8'h20;
    localparam logic [15:0] WVALUE      = 16'h0000;
    localparam logic [15:0] WINDEX      = 16'h0000;
    localparam logic [15:0] WLEN_STD    = 16'h0002;
    localparam logic [15:0] WLEN_CUS    = 16'h0004;
    localparam logic [3:0]  LAST_STD    = 4'h9;
    localparam logic [3:0]  LAST_CUS    = 4'hB;

    // Interrupt status bits
    localparam int IRQ_W    = 3;
    localparam int IRQ_SENT = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_CHG  = 2;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } usn_state_e;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [REG_ADDR_W-1:0] addr;
        logic [REG_DATA_W-1:0] wdata;
    } usn_reg_req_s;

    // Field order matches E_OVR..E_BRK
    typedef struct packed {
        logic overrun;
        logic parity;
        logic framing;
        logic brk;
    } usn_uart_evt_s;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } usn_pkt_s;

endpackage

// *** test/usn_host_sink.sv ***
// Host-side sink of notification bytes, with periodic stalls
`timescale 1ns/100ps
`default_nettype none
module usn_host_sink
    import usn_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire logic     reset,
    input  wire usn_pkt_s pkt,
    output var  logic     pkt_ready
);
    logic [7:0] rx [64];
    int         rx_n;
    logic [1:0] tick;

    // One stall in three, so one byte in two must hold through a wait
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tick <= 2'h0;
        end else begin
            tick <= (tick == 2'h2) ? 2'h0 : tick + 2'h1;
        end
    end
    assign pkt_ready = (tick != 2'h2);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_n <= 0;
        end else if (pkt.valid && pkt_ready) begin
            rx[rx_n] <= pkt.data;
            rx_n <= rx_n + 1;
        end
    end
endmodule
`default_nettype wire

// *** test/usn_notify_asserts.sv ***
// Port-level checks of the notifier
`timescale 1ns/100ps
`default_nettype none
module usn_notify_asserts
    import usn_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input wire logic                  sys_clk,
    input wire logic                  reset,
    input wire logic                  clk_en,
    input wire usn_reg_req_s          reg_req,
    input wire logic [REG_DATA_W-1:0] reg_rdata,
    input wire usn_uart_evt_s         uart_evt,
    input wire logic [NUM_PINS-1:0]   modem_pins,
    input wire logic                  pkt_ready,
    input wire usn_pkt_s              pkt,
    input wire logic [PAD_W-1:0]      pullup_en,
    input wire logic [PAD_W-1:0]      pulldown_en,
    input wire logic                  irq
);
    logic [3:0] idx;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Byte index in the packet; format is judged by the bench
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            idx <= 4'h0;
        end else if (clk_en && pkt.valid && pkt_ready) begin
            idx <= pkt.last ? 4'h0 : idx + 4'h1;
        end
    end

    chk_pd_masked: assert property ((pulldown_en & pullup_en) == 8'h00)
        else $error("Pull-down beside pull-up");
    chk_pads_reset: assert property (
        $fell(reset) |-> pullup_en == 8'hFF && pulldown_en == 8'h00)
        else $error("Pad pulls not at reset values");
    chk_first_byte: assert property ($rose(pkt.valid) |-> pkt.data == REQ_TYPE)
        else $error("Bad first byte");
    chk_code_byte: assert property (pkt.valid && idx == 4'h1 |-> pkt.data == NOTIF_CODE)
        else $error("Bad notification code");
    chk_hdr_zero: assert property (
        pkt.valid && idx >= 4'h2 && idx <= 4'h5 |-> pkt.data == 8'h00)
        else $error("Value or index byte not zero");
    chk_len_low: assert property (
        pkt.valid && idx == 4'h6 |-> pkt.data == 8'h02 || pkt.data == 8'h04)
        else $error("Bad length byte");
    chk_len_high: assert property (pkt.valid && idx == 4'h7 |-> pkt.data == 8'h00)
        else $error("Length high byte not zero");
    chk_last_index: assert property (
        pkt.valid && pkt.last |-> idx == LAST_STD || idx == LAST_CUS)
        else $error("Bad packet length");
    chk_err_trigger: assert property (
        uart_evt != 4'h0 && !pkt.valid |-> ##[1:3] pkt.valid)
        else $error("Line event raised no packet");
endmodule

bind usn_notify usn_notify_asserts #(.SYNC_STAGES(SYNC_STAGES)) usn_notify_asserts_inst (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .uart_evt(uart_evt), .modem_pins(modem_pins),
    .pkt_ready(pkt_ready), .pkt(pkt), .pullup_en(pullup_en),
    .pulldown_en(pulldown_en), .irq(irq)
);
`default_nettype wire

// *** test/usn_notify_test.sv ***
// Self-checking bench of the notifier
`timescale 1ns/100ps
`default_nettype none
module usn_notify_test
    import usn_pkg::*;
;
    logic          sys_clk   = 1'b0;
    logic          reset     = 1'b1;
    logic          clk_en    = 1'b1;
    usn_reg_req_s  req       = '0;
    usn_uart_evt_s evt       = '0;
    logic [5:0]    pins      = 6'h00;
    logic          pkt_ready;
    usn_pkt_s      pkt;
    logic [15:0]   rdata;
    logic [7:0]    pu;
    logic [7:0]    pd;
    logic          irq;
    int            err_total = 0;
    int            checks    = 0;
    int            cyc       = 0;
    int            base      = 0;

    always #4 sys_clk = ~sys_clk;

    usn_notify usn_notify_inst (
        .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .reg_req(req),
        .reg_rdata(rdata), .uart_evt(evt), .modem_pins(pins), .pkt_ready(pkt_ready),
        .pkt(pkt), .pullup_en(pu), .pulldown_en(pd), .irq(irq)
    );
    usn_host_sink usn_host_sink_inst (
        .sys_clk(sys_clk), .reset(reset), .pkt(pkt), .pkt_ready(pkt_ready)
    );

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp16({8'h00, got}, {8'h00, exp});
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp16({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic wrap_up();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 cmp16(rdata, exp);
    endtask
    task automatic evt_pulse(input usn_uart_evt_s e);
        @(posedge sys_clk);
        evt <= e;
        @(posedge sys_clk);
        evt <= '0;
    endtask
    // Bytes come from the sink's log, so stalls cannot hide a lost byte
    task automatic get_pkt(input logic [31:0] pay, input logic cus);
        logic [7:0] exp [12];
        int         n;
        n = cus ? 12 : 10;
        exp = '{REQ_TYPE, NOTIF_CODE, 8'h00, 8'h00, 8'h00, 8'h00, cus ? 8'h04 : 8'h02,
                8'h00, pay[7:0], pay[15:8], pay[23:16], pay[31:24]};
        for (int i = 0; i < 200 && usn_host_sink_inst.rx_n < base + n; i++) begin
            @(posedge sys_clk);
        end
        for (int i = 0; i < n; i++) begin
            cmp8(usn_host_sink_inst.rx[base + i], exp[i]);
        end
        base = base + n;
    endtask

    task automatic t_reset_regs();
        #1 cmp8(pu, 8'hFF);
        cmp8(pd, 8'h00);
        reg_rd(OFS_PULLUP, 16'h00FF);
        reg_rd(OFS_PULLDOWN, 16'h0000);
        reg_rd(OFS_FORMAT, 16'h0000);
        reg_rd(8'h60, 16'h0000);
    endtask
    task automatic t_pull_mask();
        reg_wr(OFS_PULLUP, 16'h000F);
        reg_wr(OFS_PULLDOWN, 16'h00FF);
        repeat (2) @(posedge sys_clk);
        #1 cmp8(pd, 8'hF0);
        cmp8(pu, 8'h0F);
        reg_rd(OFS_PULLDOWN, 16'h00FF);
        reg_wr(OFS_PULLUP, 16'h00FF);
        repeat (2) @(posedge sys_clk);
        #1 cmp8(pd, 8'h00);
    endtask
    task automatic t_masked_pins();
        reg_wr(OFS_GPIO_MASK, 16'h003F);
        @(posedge sys_clk);
        pins <= 6'h07;
        repeat (12) begin
            @(posedge sys_clk);
            #1 cmp1(pkt.valid, 1'b0);
        end
        reg_rd(OFS_GPIO_MASK, 16'h003F);
        reg_rd(OFS_FLAGS, 16'h0007);
    endtask
    // A write while the clock enable is low must be lost
    task automatic t_freeze();
        @(posedge sys_clk);
        clk_en <= 1'b0;
        reg_wr(OFS_PULLUP, 16'h0000);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        #1 cmp8(pu, 8'hFF);
        reg_rd(OFS_PULLUP, 16'h00FF);
    endtask
    task automatic t_std_pkt();
        evt_pulse('{overrun: 1'b1, parity: 1'b0, framing: 1'b0, brk: 1'b1});
        get_pkt(32'h0000_004F, 1'b0);
        reg_rd(OFS_IRQ_STAT, 16'h0007);
    endtask
    task automatic t_cus_chg();
        reg_wr(OFS_GPIO_MASK, 16'h0000);
        reg_wr(OFS_FORMAT, 16'h0001);
        reg_wr(OFS_IRQ_MASK, 16'h0001);
        #1 cmp1(irq, 1'b0);
        @(posedge sys_clk);
        pins <= 6'h27;
        get_pkt(32'h0000_2720, 1'b1);
        repeat (3) @(posedge sys_clk);
        #1 cmp1(irq, 1'b1);
        reg_rd(OFS_IRQ_STAT, 16'h0005);
        repeat (2) @(posedge sys_clk);
        #1 cmp1(irq, 1'b0);
    endtask
    task automatic t_cus_err();
        evt_pulse('{overrun: 1'b0, parity: 1'b1, framing: 1'b1, brk: 1'b0});
        // Format change mid-packet must not alter this packet
        reg_wr(OFS_FORMAT, 16'h0000);
        get_pkt(32'h0006_2700, 1'b1);
    endtask

    // Run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_regs();
        t_pull_mask();
        t_freeze();
        t_masked_pins();
        t_std_pkt();
        t_cus_chg();
        t_cus_err();
        wrap_up();
    end
endmodule
`default_nettype wire
